// ### hw/ssw_pkg.sv
// Purpose: Shared constants for the supply supervisor and watchdog block.
// Assumes: 50 MHz pclk, APB register access with 32-bit data.
// Notes: Long counts are defaults for module parameters of the top.
package ssw_pkg;
  localparam int unsigned SSW_CLK_HZ = 50_000_000;
  localparam int unsigned SSW_CLK_MHZ = SSW_CLK_HZ / 1_000_000;

  // Times in their own units, as printed
  localparam int unsigned SSW_RESET_HOLD_MS = 200;
  localparam int unsigned SSW_WD_DEFAULT_MS = 1600;
  localparam int unsigned SSW_WD_US_PER_NF_X10 = 21;
  localparam int unsigned SSW_FAULT_PULSE_MS = 1;
  localparam int unsigned SSW_PULSE_LEAD_NS = 70;
  localparam int unsigned SSW_GATE_GRACE_US = 15;
  localparam int unsigned SSW_PB_CLEAR_US = 15;

  // Cycle counts derived from the clock rate
  localparam int unsigned SSW_RESET_HOLD_CYC = SSW_RESET_HOLD_MS * (SSW_CLK_HZ / 1000);
  localparam int unsigned SSW_WD_DEFAULT_CYC = SSW_WD_DEFAULT_MS * (SSW_CLK_HZ / 1000);
  localparam int unsigned SSW_WD_CYC_PER_NF = SSW_WD_US_PER_NF_X10 * (SSW_CLK_HZ / 10_000);
  localparam int unsigned SSW_FAULT_PULSE_CYC = SSW_FAULT_PULSE_MS * (SSW_CLK_HZ / 1000);
  localparam int unsigned SSW_PULSE_LEAD_CYC = (SSW_PULSE_LEAD_NS * SSW_CLK_MHZ + 999) / 1000;
  localparam int unsigned SSW_GATE_GRACE_CYC = SSW_GATE_GRACE_US * SSW_CLK_MHZ;
  localparam int unsigned SSW_PB_CLEAR_CYC = SSW_PB_CLEAR_US * SSW_CLK_MHZ;

  // Register byte offsets
  localparam logic [11:0] SSW_STATUS_OFS = 12'h000;
  localparam logic [11:0] SSW_CONFIG_OFS = 12'h004;
  localparam logic [11:0] SSW_FAULTS_OFS = 12'h008;

  // Status register fields
  localparam int unsigned SSW_ST_RESET_N = 0;
  localparam int unsigned SSW_ST_ON_BACKUP = 1;
  localparam int unsigned SSW_ST_POWERFAIL_N = 2;
  localparam int unsigned SSW_ST_EARLY_WARN_N = 3;
  localparam int unsigned SSW_ST_FAULT_N = 4;
  localparam int unsigned SSW_ST_FAULT_PULSE_N = 5;
  localparam int unsigned SSW_ST_WD_ACTIVE = 6;
  localparam int unsigned SSW_ST_CS_GATED_N = 7;

  // Config register: timing capacitor value in nF
  localparam int unsigned SSW_CFG_CAP_LSB = 0;
  localparam int unsigned SSW_CFG_CAP_W = 8;
  localparam logic [7:0] SSW_CFG_CAP_RESET = 8'h0a;

  // Synchroniser lane positions
  localparam int unsigned SSW_SY_SUPPLY_LOW = 0;
  localparam int unsigned SSW_SY_EARLY_WARN = 1;
  localparam int unsigned SSW_SY_MAIN_ABOVE = 2;
  localparam int unsigned SSW_SY_PUSHBTN_N = 3;
  localparam int unsigned SSW_SY_STROBE_HI = 4;
  localparam int unsigned SSW_SY_STROBE_LO = 5;
  localparam int unsigned SSW_SY_PF_BELOW = 6;
  localparam int unsigned SSW_SY_TSEL = 7;
  localparam int unsigned SSW_SY_W = 8;
  localparam logic [7:0] SSW_SY_RESET = 8'h08;

  typedef enum logic [1:0] {
    SSW_WD_OFF = 2'b00,
    SSW_WD_RUN = 2'b01,
    SSW_WD_LEAD = 2'b10,
    SSW_WD_PULSE = 2'b11
  } ssw_wd_state_t;
endpackage : ssw_pkg

// ### hw/ssw_supervisor.sv
// Purpose: Supply supervisor: reset generator, activity watchdog, chip-select gate, backup switch flags.
// Assumes: Comparator results arrive as digital levels; APB slave for configuration and status.
// Notes: Every interval is a count of pclk cycles.
`timescale 1ns/1ps
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter int unsigned RESET_HOLD_CYC = SSW_RESET_HOLD_CYC,
  parameter int unsigned WD_DEFAULT_CYC = SSW_WD_DEFAULT_CYC,
  parameter int unsigned WD_CYC_PER_NF = SSW_WD_CYC_PER_NF,
  parameter int unsigned FAULT_PULSE_CYC = SSW_FAULT_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_low_in,
  input wire logic early_warn_in,
  input wire logic main_above_backup_in,
  input wire logic powerfail_sense_in,
  input wire logic pushbutton_reset_n,
  input wire logic strobe_high_in,
  input wire logic strobe_low_in,
  input wire logic timeout_select_in,
  input wire logic chip_select_raw_n,
  output logic supply_from_backup,
  output logic battery_select_flag,
  output logic powerfail_flag_n,
  output logic early_supply_warn_n,
  output logic reset_n,
  output logic activity_fault_n,
  output logic activity_fault_pulse_n,
  output logic chip_select_gated_n
);
  logic [SSW_SY_W-1:0] sync_a;
  logic [SSW_SY_W-1:0] sync_b;
  logic [7:0] cap_nf;
  logic [31:0] fault_count;
  logic [31:0] hold_cnt;
  logic [31:0] wd_cnt;
  logic [31:0] wd_limit;
  logic [15:0] pb_cnt;
  logic [15:0] grace_cnt;
  logic pb_clear;
  logic reset_cause;
  logic strobe_mid;
  logic strobe_level;
  logic last_level;
  logic strobe_edge;
  logic wd_enable;
  logic grace_open;
  logic next_cs_n;
  logic [31:0] status_word;
  ssw_wd_state_t wd_state;

  // Inputs are comparator levels; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= SSW_SY_RESET;
      sync_b <= SSW_SY_RESET;
    end
    else
    begin
      sync_a <= {timeout_select_in, powerfail_sense_in, strobe_low_in, strobe_high_in,
                 pushbutton_reset_n, main_above_backup_in, early_warn_in, supply_low_in};
      sync_b <= sync_a;
    end
  end

  // Supply routing keeps its last choice in the band where neither condition holds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      supply_from_backup <= 1'b0;
    else if (sync_b[SSW_SY_MAIN_ABOVE] && !sync_b[SSW_SY_SUPPLY_LOW])
      supply_from_backup <= 1'b0;
    else if (!sync_b[SSW_SY_MAIN_ABOVE] && sync_b[SSW_SY_SUPPLY_LOW])
      supply_from_backup <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      battery_select_flag <= 1'b0;
      powerfail_flag_n <= 1'b1;
      early_supply_warn_n <= 1'b1;
    end
    else
    begin
      battery_select_flag <= supply_from_backup;
      powerfail_flag_n <= !sync_b[SSW_SY_PF_BELOW];
      early_supply_warn_n <= !sync_b[SSW_SY_EARLY_WARN];
    end
  end

  // Pushbutton low long enough counts as a full clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pb_cnt <= 16'h0000;
    else if (sync_b[SSW_SY_PUSHBTN_N])
      pb_cnt <= 16'h0000;
    else if (!pb_clear)
      pb_cnt <= pb_cnt + 16'h0001;
  end
  assign pb_clear = (pb_cnt >= 16'(SSW_PB_CLEAR_CYC));

  assign reset_cause = sync_b[SSW_SY_SUPPLY_LOW] || !sync_b[SSW_SY_PUSHBTN_N];

  // Hold counter restarts while any cause is present, so hold time runs from release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_cnt <= 32'h0000_0000;
      reset_n <= 1'b0;
    end
    else if (reset_cause)
    begin
      hold_cnt <= 32'h0000_0000;
      reset_n <= 1'b0;
    end
    else if (hold_cnt < RESET_HOLD_CYC)
    begin
      hold_cnt <= hold_cnt + 32'h0000_0001;
      reset_n <= 1'b0;
    end
    else
      reset_n <= 1'b1;
  end

  // Three-level strobe: high and low comparators both idle means floating
  assign strobe_mid = !sync_b[SSW_SY_STROBE_HI] && !sync_b[SSW_SY_STROBE_LO];
  assign strobe_level = sync_b[SSW_SY_STROBE_HI];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_level <= 1'b0;
    else if (!strobe_mid)
      last_level <= strobe_level;
  end
  // A 100ns pulse spans several cycles, so both of its edges are seen
  assign strobe_edge = !strobe_mid && (strobe_level != last_level);

  assign wd_enable = reset_n && !supply_from_backup && !strobe_mid && !pb_clear;

  always_comb
  begin
    if (sync_b[SSW_SY_TSEL])
      wd_limit = WD_DEFAULT_CYC;
    else if (cap_nf == 8'h00)
      wd_limit = WD_CYC_PER_NF;
    else
      wd_limit = 32'({24'h000000, cap_nf} * WD_CYC_PER_NF);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_state <= SSW_WD_OFF;
      wd_cnt <= 32'h0000_0000;
    end
    else if (!wd_enable)
    begin
      wd_state <= SSW_WD_OFF;
      wd_cnt <= 32'h0000_0000;
    end
    else
    begin
      case (wd_state)
        SSW_WD_OFF:
        begin
          wd_state <= SSW_WD_RUN;
          wd_cnt <= 32'h0000_0000;
        end
        SSW_WD_RUN:
        begin
          if (strobe_edge)
            wd_cnt <= 32'h0000_0000;
          else if (wd_cnt + 32'h0000_0001 >= wd_limit)
          begin
            wd_state <= SSW_WD_LEAD;
            wd_cnt <= 32'h0000_0000;
          end
          else
            wd_cnt <= wd_cnt + 32'h0000_0001;
        end
        SSW_WD_LEAD:
        begin
          if (wd_cnt + 32'h0000_0001 >= SSW_PULSE_LEAD_CYC)
            wd_state <= SSW_WD_PULSE;
          wd_cnt <= wd_cnt + 32'h0000_0001;
        end
        SSW_WD_PULSE:
        begin
          // The next timeout period runs from the pulse end
          if (wd_cnt + 32'h0000_0001 >= FAULT_PULSE_CYC)
          begin
            wd_state <= SSW_WD_RUN;
            wd_cnt <= 32'h0000_0000;
          end
          else
            wd_cnt <= wd_cnt + 32'h0000_0001;
        end
        default:
          wd_state <= SSW_WD_OFF;
      endcase
    end
  end

  // Pulse is low through the lead and the pulse phases
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      activity_fault_pulse_n <= 1'b1;
    else if (!wd_enable)
      activity_fault_pulse_n <= 1'b1;
    else if (wd_state == SSW_WD_RUN && !strobe_edge && wd_cnt + 32'h0000_0001 >= wd_limit)
      activity_fault_pulse_n <= 1'b0;
    else if (wd_state == SSW_WD_PULSE && wd_cnt + 32'h0000_0001 >= FAULT_PULSE_CYC)
      activity_fault_pulse_n <= 1'b1;
  end

  // Fault level falls at the end of the lead and holds until a strobe edge or until wd_enable drops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      activity_fault_n <= 1'b1;
    else if (!wd_enable || strobe_edge)
      activity_fault_n <= 1'b1;
    else if (wd_state == SSW_WD_LEAD && wd_cnt + 32'h0000_0001 >= SSW_PULSE_LEAD_CYC)
      activity_fault_n <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_count <= 32'h0000_0000;
    else if (pb_clear)
      fault_count <= 32'h0000_0000;
    else if (wd_enable && wd_state == SSW_WD_LEAD && wd_cnt == 32'h0000_0000)
      fault_count <= fault_count + 32'h0000_0001;
  end

  // Grace window lets a write cycle in flight at reset assertion finish
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      grace_cnt <= 16'h0000;
      grace_open <= 1'b0;
    end
    else if (reset_n && !reset_cause)
    begin
      grace_cnt <= 16'h0000;
      grace_open <= !chip_select_raw_n;
    end
    else if (grace_open)
    begin
      if (chip_select_raw_n || pb_clear || grace_cnt + 16'h0001 >= 16'(SSW_GATE_GRACE_CYC))
        grace_open <= 1'b0;
      grace_cnt <= grace_cnt + 16'h0001;
    end
  end

  always_comb
  begin
    if (reset_n && !reset_cause)
      next_cs_n = chip_select_raw_n;
    else if (grace_open && !chip_select_raw_n && !pb_clear)
      next_cs_n = 1'b0;
    else
      next_cs_n = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chip_select_gated_n <= 1'b1;
    else
      chip_select_gated_n <= next_cs_n;
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[SSW_ST_RESET_N] = reset_n;
    status_word[SSW_ST_ON_BACKUP] = supply_from_backup;
    status_word[SSW_ST_POWERFAIL_N] = powerfail_flag_n;
    status_word[SSW_ST_EARLY_WARN_N] = early_supply_warn_n;
    status_word[SSW_ST_FAULT_N] = activity_fault_n;
    status_word[SSW_ST_FAULT_PULSE_N] = activity_fault_pulse_n;
    status_word[SSW_ST_WD_ACTIVE] = (wd_state != SSW_WD_OFF);
    status_word[SSW_ST_CS_GATED_N] = chip_select_gated_n;
  end

  // APB: zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr != SSW_STATUS_OFS) && (paddr != SSW_CONFIG_OFS)
                   && (paddr != SSW_FAULTS_OFS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == SSW_STATUS_OFS)
        prdata <= status_word;
      else if (paddr == SSW_CONFIG_OFS)
        prdata <= {24'h000000, cap_nf};
      else if (paddr == SSW_FAULTS_OFS)
        prdata <= fault_count;
      else
        prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap_nf <= SSW_CFG_CAP_RESET;
    else if (psel && penable && pwrite && paddr == SSW_CONFIG_OFS)
      cap_nf <= pwdata[SSW_CFG_CAP_LSB +: SSW_CFG_CAP_W];
  end
endmodule : ssw_supervisor

// ### tb/ssw_host_model.sv
// Purpose: Host side of the activity strobe, as seen by the two strobe comparators.
// Assumes: mode 0 unconnected, 1 held high, 2 level toggling, 3 short high pulse each period.
// Notes: A 100ns pulse is 5 cycles at 50 MHz.
`timescale 1ns/1ps
module ssw_host_model #(
  parameter int unsigned HALF_CYC = 100
) (
  input wire logic pclk,
  input wire logic [1:0] mode,
  output logic strobe_high_in,
  output logic strobe_low_in
);
  int unsigned cnt = 0;
  logic level = 1'b0;
  // Strobe lines settle on the first edge, while the block is still held in reset
  always @(posedge pclk)
  begin
    cnt <= (cnt >= HALF_CYC - 1) ? 0 : cnt + 1;
    if (cnt == HALF_CYC - 1)
    begin
      level <= !level;
    end
    case (mode)
      2'd0: {strobe_high_in, strobe_low_in} <= 2'b00;
      2'd1: {strobe_high_in, strobe_low_in} <= 2'b10;
      2'd2: {strobe_high_in, strobe_low_in} <= {level, !level};
      default: {strobe_high_in, strobe_low_in} <= (cnt < 5) ? 2'b10 : 2'b01;
    endcase
  end
endmodule : ssw_host_model

// ### tb/ssw_supervisor_monitor.sv
// Purpose: Port-level checks of the supervisor.
// Assumes: Inputs pass three edges before an output reacts, except chip_select_raw_n, which passes one.
// Notes: Long intervals are measured by helper counters; only quiet_cnt saturates, the others wrap.
`timescale 1ns/1ps
module ssw_supervisor_monitor
  import ssw_pkg::*;
#(
  parameter int unsigned RESET_HOLD_CYC = 50,
  parameter int unsigned FAULT_PULSE_CYC = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic supply_low_in,
  input wire logic main_above_backup_in,
  input wire logic powerfail_sense_in,
  input wire logic pushbutton_reset_n,
  input wire logic strobe_high_in,
  input wire logic strobe_low_in,
  input wire logic chip_select_raw_n,
  input wire logic supply_from_backup,
  input wire logic battery_select_flag,
  input wire logic powerfail_flag_n,
  input wire logic reset_n,
  input wire logic activity_fault_n,
  input wire logic activity_fault_pulse_n,
  input wire logic chip_select_gated_n
);
  logic [31:0] quiet_cnt;
  logic [15:0] gate_cnt;
  logic [15:0] low_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_cnt <= '0;
      gate_cnt <= '0;
      low_cnt <= '0;
    end
    else
    begin
      quiet_cnt <= (!pushbutton_reset_n || supply_low_in) ? '0 : quiet_cnt + {31'h0, ~&quiet_cnt};
      gate_cnt <= (!reset_n && !chip_select_gated_n) ? gate_cnt + 16'h1 : '0;
      low_cnt <= !activity_fault_pulse_n ? low_cnt + 16'h1 : '0;
    end
  end
  sequence s_lead;
    (activity_fault_n && !activity_fault_pulse_n) [*4] ##1 !activity_fault_n;
  endsequence
  a_backup_route: assert property ((supply_low_in && !main_above_backup_in) [*4] |-> supply_from_backup)
    else $error("supply not routed from backup");
  a_main_route: assert property ((!supply_low_in && main_above_backup_in) [*4] |-> !supply_from_backup)
    else $error("supply not routed from main");
  a_flag_follows: assert property (battery_select_flag == $past(supply_from_backup))
    else $error("battery flag does not follow routing");
  a_powerfail_level: assert property (powerfail_sense_in [*4] |-> !powerfail_flag_n)
    else $error("power-fail flag not low");
  a_reset_pushbtn: assert property ((!pushbutton_reset_n) [*4] |-> !reset_n)
    else $error("reset released while pushbutton low");
  a_reset_hold: assert property ($rose(reset_n) |-> quiet_cnt inside {[RESET_HOLD_CYC:RESET_HOLD_CYC + 8]})
    else $error("reset hold time wrong");
  a_fault_mid: assert property ((!strobe_high_in && !strobe_low_in) [*5] |-> activity_fault_n)
    else $error("fault low with strobe unconnected");
  a_fault_reset: assert property ((!reset_n) [*2] |-> activity_fault_n)
    else $error("fault low during reset");
  a_pulse_lead: assert property ($fell(activity_fault_pulse_n) && activity_fault_n |-> s_lead)
    else $error("fault level not four cycles after pulse");
  a_pulse_width: assert property ($rose(activity_fault_pulse_n) |-> low_cnt == 16'(FAULT_PULSE_CYC))
    else $error("fault pulse width wrong");
  a_gate_follows: assert property (!chip_select_gated_n |-> !$past(chip_select_raw_n))
    else $error("gated select low without raw select");
  a_gate_bound: assert property (gate_cnt <= 16'(SSW_GATE_GRACE_CYC + 1))
    else $error("gated select low too long in reset");
endmodule : ssw_supervisor_monitor
bind ssw_supervisor ssw_supervisor_monitor #(.RESET_HOLD_CYC(RESET_HOLD_CYC), .FAULT_PULSE_CYC(FAULT_PULSE_CYC))
  ssw_supervisor_monitor_i (.pclk, .presetn, .supply_low_in, .main_above_backup_in, .powerfail_sense_in,
  .pushbutton_reset_n, .strobe_high_in, .strobe_low_in, .chip_select_raw_n, .supply_from_backup,
  .battery_select_flag, .powerfail_flag_n, .reset_n, .activity_fault_n, .activity_fault_pulse_n,
  .chip_select_gated_n);

// ### tb/ssw_supervisor_bench.sv
// Purpose: Self-checking bench for the supervisor.
// Assumes: Short counts: hold 50, timeout 200, 20 per nF, pulse 10.
// Notes: Fault period is pulse + limit cycles; the lead lies inside the pulse.
`timescale 1ns/1ps
module ssw_supervisor_bench;
  import ssw_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, strobe_high_in, strobe_low_in;
  logic supply_low_in = 0, early_warn_in = 0, main_above_backup_in = 1, powerfail_sense_in = 0;
  logic pushbutton_reset_n = 1, timeout_select_in = 1, chip_select_raw_n = 1;
  logic supply_from_backup, battery_select_flag, powerfail_flag_n, early_supply_warn_n, reset_n;
  logic activity_fault_n, activity_fault_pulse_n, chip_select_gated_n;
  logic [1:0] mode = 2'd0;
  int errors = 0, compares = 0, tick = 0, n;
  ssw_supervisor #(.RESET_HOLD_CYC(50), .WD_DEFAULT_CYC(200), .WD_CYC_PER_NF(20), .FAULT_PULSE_CYC(10))
    ssw_supervisor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .supply_low_in, .early_warn_in, .main_above_backup_in, .powerfail_sense_in, .pushbutton_reset_n,
    .strobe_high_in, .strobe_low_in, .timeout_select_in, .chip_select_raw_n, .supply_from_backup,
    .battery_select_flag, .powerfail_flag_n, .early_supply_warn_n, .reset_n, .activity_fault_n,
    .activity_fault_pulse_n, .chip_select_gated_n);
  ssw_host_model ssw_host_model_i (.pclk, .mode, .strobe_high_in, .strobe_low_in);
  initial
  begin
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    tick++;
    if (tick == 20000)
    begin
      errors++;
      finish_test();
    end
  end
  task finish_test();
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask : cyc
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  // Counts cycles until reset is released
  task wait_rst();
    n = 0;
    while (reset_n !== 1'b1 && n < 300) begin @(posedge pclk); n++; end
  endtask : wait_rst
  // Counts cycles to the next falling edge of the fault pulse
  task wait_pulse();
    n = 0;
    while (activity_fault_pulse_n !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
    while (activity_fault_pulse_n !== 1'b0 && n < 3000) begin @(posedge pclk); n++; end
  endtask : wait_pulse
  // Counts samples over c cycles in which the fault pulse or the fault level is low
  task count_low(input int c);
    n = 0;
    repeat (c) begin @(posedge pclk); n += (activity_fault_pulse_n !== 1'b1 || activity_fault_n !== 1'b1); end
  endtask : count_low
  task t_regs();
    apb(0, SSW_CONFIG_OFS, 0); chk(rd, 32'h0000000a);
    apb(1, SSW_CONFIG_OFS, 32'h00000055); apb(0, SSW_CONFIG_OFS, 0); chk(rd, 32'h00000055);
    apb(1, SSW_STATUS_OFS, 32'hffffffff); chk(err, 0);
    apb(0, SSW_STATUS_OFS, 0); chk(rd[SSW_ST_RESET_N], 1);
    apb(0, 12'h00c, 0);
    chk(err, 1);
    chk(rd, 0);
  endtask : t_regs
  task t_timeout(input logic sel, input logic [7:0] cap, input int exp);
    timeout_select_in <= sel;
    apb(1, SSW_CONFIG_OFS, {24'h0, cap});
    mode <= 2'd1;
    wait_pulse();
    wait_pulse(); chk(n, exp);
    cyc(6); chk(activity_fault_n, 0);
    mode <= 2'd2;
    n = 0;
    while (activity_fault_n !== 1'b1 && n < 120) begin @(posedge pclk); n++; end
    chk(activity_fault_n, 1);
  endtask : t_timeout
  task t_strobe(input logic [1:0] m);
    mode <= m;
    cyc(30);
    count_low(600); chk(n, 0);
  endtask : t_strobe
  task t_supply();
    mode <= 2'd1;
    supply_low_in <= 1; main_above_backup_in <= 0; early_warn_in <= 1;
    cyc(6);
    chk(supply_from_backup, 1);
    chk(battery_select_flag, 1);
    chk(reset_n, 0);
    chk(early_supply_warn_n, 0);
    count_low(400); chk(n, 0);
    supply_low_in <= 0; main_above_backup_in <= 1; early_warn_in <= 0;
    wait_rst(); chk(n >= 50 && n <= 60, 1);
    chk({supply_from_backup, battery_select_flag, early_supply_warn_n}, 3'b001);
  endtask : t_supply
  task t_powerfail();
    powerfail_sense_in <= 1;
    cyc(5); chk({powerfail_flag_n, reset_n, supply_from_backup}, 3'b010);
    powerfail_sense_in <= 0;
    cyc(5); chk(powerfail_flag_n, 1);
  endtask : t_powerfail
  task t_gate();
    mode <= 2'd0;
    chip_select_raw_n <= 0;
    cyc(3); chk(chip_select_gated_n, 0);
    pushbutton_reset_n <= 0;
    cyc(100); chk({chip_select_gated_n, reset_n}, 2'b00);
    cyc(700); chk(chip_select_gated_n, 1);
    apb(0, SSW_FAULTS_OFS, 0); chk(rd, 0);
    pushbutton_reset_n <= 1; chip_select_raw_n <= 1;
    wait_rst(); chk(n >= 50 && n <= 60, 1);
    chip_select_raw_n <= 0;
    cyc(3); pushbutton_reset_n <= 0;
    cyc(20); chip_select_raw_n <= 1;
    cyc(4); chk(chip_select_gated_n, 1);
    pushbutton_reset_n <= 1;
    wait_rst(); chk(n >= 50 && n <= 60, 1);
  endtask : t_gate
  initial
  begin
    cyc(2);
    presetn <= 1;
    wait_rst(); chk(n >= 50 && n <= 60, 1);
    t_regs();
    t_timeout(1, 8'h0a, 210);
    t_timeout(0, 8'h03, 70);
    t_timeout(0, 8'h00, 30);
    timeout_select_in <= 1;
    t_strobe(2'd2);
    t_strobe(2'd3);
    t_strobe(2'd0);
    t_supply();
    t_powerfail();
    t_gate();
    finish_test();
  end
endmodule : ssw_supervisor_bench
